// ==== src/cmd_if_pkg.sv ====
// types shared by the bridge command interpreter
`default_nettype none
`include "cmd_if_regs.svh"
package cmd_if_pkg;
   typedef enum logic [2:0] {
      ST_CMD_WAIT, ST_CMD_CAP, ST_DECODE, ST_IN_WAIT, ST_IN_CAP, ST_OUT
   } state_type;
   typedef struct packed {
      state_type state;
      logic flag_meta;
      logic flag_sync;
      logic [31:0] dq_meta;
      logic [31:0] dq_sync;
      logic [2:0] wait_cnt;
      logic [1:0] word_idx;
      logic [31:0] opcode;
      logic [31:0] cur_addr;
      logic [31:0] remain;
      logic [31:0] dq_out;
      logic dq_oe;
      logic rd;
      logic wr;
      logic [1:0] ep;
      logic mem_we;
      logic mem_re;
      logic [11:0] mem_addr;
      logic [31:0] wdata;
      logic reg_we;
      logic [4:0] reg_index;
      logic load;
   } ctrl_type;
endpackage
`default_nettype wire

// ==== src/cmd_if_regs.svh ====
// constants for the bridge command interpreter
`ifndef CMD_IF_REGS_SVH
`define CMD_IF_REGS_SVH
`define OP_REG_READ 32'h0000_0004
`define OP_MEM_READ 32'h0000_0005
`define OP_REG_WRITE 32'h0000_0006
`define OP_MEM_WRITE 32'h0000_0007
`define OP_REG_WRITE_END 32'h0000_000E
`define OP_MEM_WRITE_END 32'h0000_000F
`define EP_COMMAND 2'h0
`define EP_HOST_TO_DEVICE 2'h1
`define EP_DEVICE_TO_HOST 2'h2
`define REG_LAST_ADDR 32'h0000_0054
`define REG_COUNT 22
`define REG_INDEX_W 5
`define MEM_WORD_BITS 12
`define WORD_BYTES 32'h0000_0004
`define FLAG_WAIT_CYC 3'h3
`define CAPTURE_WAIT_CYC 3'h3
`define OUT_FIFO_DEPTH 16
`define DATA_W 32
`endif

// ==== src/reg_area.sv ====
// internal register area reached by register commands
`default_nettype none
`include "cmd_if_regs.svh"
module reg_area
   import cmd_if_pkg::*;
(
   input wire logic clk,                          // core clock
   input wire logic rst,                          // async reset, active high
   input wire logic we,                           // write strobe
   input wire logic [`REG_INDEX_W-1:0] index,     // word index
   input wire logic [31:0] wdata,                 // write data
   output logic [31:0] rdata                      // read data, zero past the area
);
   logic [31:0] regs [`REG_COUNT];

   generate
      for (genvar i = 0; i < `REG_COUNT; i++) begin : g_reg
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               regs[i] <= 32'h0000_0000;
            end else if (we && index == `REG_INDEX_W'(i)) begin
               regs[i] <= wdata;
            end
         end
      end
   endgenerate

   assign rdata = (index < `REG_COUNT) ? regs[index] : 32'h0000_0000;
endmodule
`default_nettype wire

// ==== src/usb_fifo_command_interpreter.sv ====
// command interpreter mastering the bridge slave fifo port
// Function
// - a command packet is four 32-bit words: opcode, address, count, reserved.
// - opcode 4 reads one register, opcode 5 reads a memory block.
// - opcode 6 starts a register write, opcode E ends it.
// - opcode 7 starts a memory write, opcode F ends it.
// - the address word is where writes go and reads come from.
// - count gives 32-bit accesses, one per four bytes.
// - register write takes one data word from the host-to-device endpoint.
// - register read returns one word on the device-to-host endpoint.
// - memory write streams count words from host-to-device from the address.
// - memory read sends count words from the address to the host.
// - registers span byte addresses 0x00 to 0x54; memory uses 32-bit addresses.
// - memory mirrors every 16KB.
// - keep waiting on the command endpoint and act on each packet.
// - this logic masters the bridge port over a 32-bit data bus.
`default_nettype none
`include "cmd_if_regs.svh"
module usb_fifo_command_interpreter
   import cmd_if_pkg::*;
(
   input wire logic clk,                // core clock, 250 MHz
   input wire logic rst,                // async reset, active high
   output logic [1:0] bridge_ep,        // endpoint select to bridge
   output logic bridge_rd,              // read strobe, one word per pulse
   output logic bridge_wr,              // write strobe, one word per pulse
   input wire logic bridge_flag,        // selected endpoint ready (pin)
   input wire logic [31:0] bridge_dq_in,// data bus input (pin)
   output logic [31:0] bridge_dq_out,   // data bus output
   output logic bridge_dq_oe,           // data bus output enable
   output logic mem_we,                 // memory write strobe
   output logic mem_re,                 // memory read strobe
   output logic [11:0] mem_addr,        // memory word index, 16KB window
   output logic [31:0] mem_wdata,       // memory write data
   input wire logic [31:0] mem_rdata    // memory data, sampled at the clock edge that ends mem_re
);
   ctrl_type s;
   ctrl_type next_s;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [31:0] fifo_out_data;
   logic [31:0] fifo_in_data;
   logic [31:0] reg_rdata;
   logic reg_hit;
   logic reg_op;

   function automatic logic known_op(input logic [31:0] op);
      case (op)
         `OP_REG_READ, `OP_MEM_READ, `OP_REG_WRITE, `OP_MEM_WRITE,
         `OP_REG_WRITE_END, `OP_MEM_WRITE_END: known_op = 1'b1;
         default: known_op = 1'b0;
      endcase
   endfunction

   assign reg_hit = (s.cur_addr <= `REG_LAST_ADDR);
   assign reg_op = (s.opcode == `OP_REG_READ) || (s.opcode == `OP_REG_WRITE);
   assign fifo_in_data = reg_op ? (reg_hit ? reg_rdata : 32'h0000_0000) : mem_rdata;

   reg_area u_regs (
      .clk(clk),
      .rst(rst),
      .we(s.reg_we),
      .index(s.reg_index),
      .wdata(s.wdata),
      .rdata(reg_rdata)
   );

   // fifo decouples reads from the bridge; when the host stalls it fills
   // and holds back further memory fetches
   word_fifo #(.WIDTH(`DATA_W), .DEPTH(`OUT_FIFO_DEPTH)) u_out_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(s.load),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   always_comb begin
      next_s = s;
      fifo_out_ready = 1'b0;
      // pins come from the bridge's clock; only the second flop is read
      next_s.flag_meta = bridge_flag;
      next_s.flag_sync = s.flag_meta;
      next_s.dq_meta = bridge_dq_in;
      next_s.dq_sync = s.dq_meta;
      next_s.rd = 1'b0;
      next_s.wr = 1'b0;
      next_s.dq_oe = 1'b0;
      next_s.mem_we = 1'b0;
      next_s.mem_re = 1'b0;
      next_s.reg_we = 1'b0;
      next_s.load = 1'b0;
      // one shared settle counter; each strobe reloads it so strobes stay spaced
      if (s.wait_cnt != 3'h0) begin
         next_s.wait_cnt = 3'(s.wait_cnt - 1'b1);
      end
      case (s.state)
         ST_CMD_WAIT: begin
            next_s.ep = `EP_COMMAND;
            if (s.wait_cnt == 3'h0 && s.flag_sync) begin
               next_s.rd = 1'b1;
               next_s.wait_cnt = `CAPTURE_WAIT_CYC;
               next_s.state = ST_CMD_CAP;
            end
         end
         ST_CMD_CAP: begin
            if (s.wait_cnt == 3'h0) begin
               next_s.wait_cnt = `FLAG_WAIT_CYC;
               next_s.word_idx = 2'(s.word_idx + 1'b1);
               next_s.state = ST_CMD_WAIT;
               case (s.word_idx)
                  2'h0: next_s.opcode = s.dq_sync;
                  2'h1: next_s.cur_addr = s.dq_sync;
                  2'h2: next_s.remain = s.dq_sync;
                  default: next_s.state = ST_DECODE;
               endcase
            end
         end
         ST_DECODE: begin
            next_s.state = ST_CMD_WAIT;
            case (s.opcode)
               `OP_REG_READ: begin
                  next_s.remain = 32'h0000_0001;
                  next_s.state = ST_OUT;
               end
               `OP_MEM_READ: begin
                  if (s.remain != 32'h0000_0000) begin
                     next_s.state = ST_OUT;
                  end
               end
               `OP_REG_WRITE: begin
                  next_s.remain = 32'h0000_0001;
                  next_s.state = ST_IN_WAIT;
               end
               `OP_MEM_WRITE: begin
                  if (s.remain != 32'h0000_0000) begin
                     next_s.state = ST_IN_WAIT;
                  end
               end
               // end markers close the write; nothing is left to do
               `OP_REG_WRITE_END: next_s.state = ST_CMD_WAIT;
               `OP_MEM_WRITE_END: next_s.state = ST_CMD_WAIT;
               default: next_s.state = ST_CMD_WAIT;
            endcase
            // an idle return leaves the data endpoint so its flag cannot start a packet
            if (next_s.state == ST_OUT) begin
               next_s.ep = `EP_DEVICE_TO_HOST;
            end else if (next_s.state == ST_IN_WAIT) begin
               next_s.ep = `EP_HOST_TO_DEVICE;
            end else begin
               next_s.ep = `EP_COMMAND;
            end
            next_s.wait_cnt = `FLAG_WAIT_CYC;
         end
         ST_IN_WAIT: begin
            if (s.wait_cnt == 3'h0 && s.flag_sync) begin
               next_s.rd = 1'b1;
               next_s.wait_cnt = `CAPTURE_WAIT_CYC;
               next_s.state = ST_IN_CAP;
            end
         end
         ST_IN_CAP: begin
            if (s.wait_cnt == 3'h0) begin
               next_s.wdata = s.dq_sync;
               // a write past the register area still takes its word off the bridge
               if (reg_op) begin
                  next_s.reg_we = reg_hit;
                  next_s.reg_index = s.cur_addr[6:2];
               end else begin
                  next_s.mem_we = 1'b1;
                  next_s.mem_addr = s.cur_addr[13:2];
               end
               next_s.cur_addr = s.cur_addr + `WORD_BYTES;
               next_s.remain = s.remain - 32'h0000_0001;
               next_s.wait_cnt = `FLAG_WAIT_CYC;
               next_s.state = (s.remain == 32'h0000_0001) ? ST_CMD_WAIT : ST_IN_WAIT;
               if (s.remain == 32'h0000_0001) begin
                  next_s.ep = `EP_COMMAND;
               end
            end
         end
         ST_OUT: begin
            // fetch and advance alternate so each pushed word sees its own address
            if (s.load) begin
               next_s.cur_addr = s.cur_addr + `WORD_BYTES;
            end else if (s.remain != 32'h0000_0000 && fifo_in_ready) begin
               next_s.load = 1'b1;
               next_s.remain = s.remain - 32'h0000_0001;
               next_s.reg_index = s.cur_addr[6:2];
               next_s.mem_re = !reg_op;
               next_s.mem_addr = s.cur_addr[13:2];
            end
            if (s.wait_cnt == 3'h0 && s.flag_sync && fifo_out_valid) begin
               fifo_out_ready = 1'b1;
               next_s.wr = 1'b1;
               next_s.dq_oe = 1'b1;
               next_s.dq_out = fifo_out_data;
               next_s.wait_cnt = `FLAG_WAIT_CYC;
            end else if (s.remain == 32'h0000_0000 && !s.load && !fifo_out_valid
                         && s.wait_cnt == 3'h0) begin
               next_s.state = ST_CMD_WAIT;
               next_s.ep = `EP_COMMAND;
               next_s.wait_cnt = `FLAG_WAIT_CYC;
            end
         end
         default: next_s.state = ST_CMD_WAIT;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.state <= ST_CMD_WAIT;
         s.ep <= `EP_COMMAND;
      end else begin
         s <= next_s;
      end
   end

   assign bridge_ep = s.ep;
   assign bridge_rd = s.rd;
   assign bridge_wr = s.wr;
   assign bridge_dq_out = s.dq_out;
   assign bridge_dq_oe = s.dq_oe;
   assign mem_we = s.mem_we;
   assign mem_re = s.mem_re;
   assign mem_addr = s.mem_addr;
   assign mem_wdata = s.wdata;

   strobe_single_a: assert property (@(posedge clk) disable iff (rst)
      (s.rd || s.wr) |=> !(s.rd || s.wr)) else $error("bridge strobe longer than one cycle");
   strobe_excl_a: assert property (@(posedge clk) disable iff (rst)
      !(s.rd && s.wr)) else $error("read and write strobe together");
   wr_drives_bus_a: assert property (@(posedge clk) disable iff (rst)
      s.wr |-> s.dq_oe && s.ep == `EP_DEVICE_TO_HOST) else $error("write without drive");
   cmd_endpoint_a: assert property (@(posedge clk) disable iff (rst)
      s.rd && s.state == ST_CMD_CAP |-> s.ep == `EP_COMMAND)
      else $error("command read on wrong endpoint");
   packet_len_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_CMD_CAP ##1 s.state == ST_DECODE |-> $past(s.word_idx) == 2'h3
      && s.word_idx == 2'h0)
      else $error("decode before four words");
   unknown_drop_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_DECODE && !known_op(s.opcode) |=> s.state == ST_CMD_WAIT && !s.rd)
      else $error("unknown opcode not dropped");
   mem_read_go_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_DECODE && s.opcode == `OP_MEM_READ && s.remain != 32'h0000_0000
      |=> s.state == ST_OUT ##[1:3] s.mem_re) else $error("memory read not started");
   reg_write_go_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_IN_CAP && s.wait_cnt == 3'h0 && s.opcode == `OP_REG_WRITE && reg_hit
      |=> s.reg_we && s.wdata == $past(s.dq_sync) && !s.mem_we)
      else $error("register write lost");
   reg_bound_a: assert property (@(posedge clk) disable iff (rst)
      s.reg_we |-> s.reg_index < `REG_COUNT) else $error("register write out of area");
   mem_write_mode_a: assert property (@(posedge clk) disable iff (rst)
      s.mem_we |-> s.opcode == `OP_MEM_WRITE && s.mem_addr == $past(s.cur_addr[13:2]))
      else $error("memory write with wrong opcode or address");
   end_marker_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_DECODE && (s.opcode == `OP_REG_WRITE_END || s.opcode == `OP_MEM_WRITE_END)
      |=> s.state == ST_CMD_WAIT) else $error("end marker not closing");
   rd_after_flag_a: assert property (@(posedge clk) disable iff (rst)
      (s.rd || s.wr) |-> $past(s.flag_sync)) else $error("strobe while endpoint not ready");
   strobe_gap_a: assert property (@(posedge clk) disable iff (rst)
      (s.rd || s.wr) |=> !(s.rd || s.wr) [*3]) else $error("strobes closer than four cycles");
   word_capture_a: assert property (@(posedge clk) disable iff (rst)
      s.rd && s.state == ST_CMD_CAP && s.word_idx == 2'h0
      |-> ##4 s.opcode == $past(bridge_dq_in, 3)) else $error("opcode word not captured");
   out_endpoint_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_OUT |-> s.ep == `EP_DEVICE_TO_HOST)
      else $error("data out on wrong endpoint");
   in_endpoint_a: assert property (@(posedge clk) disable iff (rst)
      s.state inside {ST_IN_WAIT, ST_IN_CAP} |-> s.ep == `EP_HOST_TO_DEVICE)
      else $error("data in on wrong endpoint");
   read_addr_a: assert property (@(posedge clk) disable iff (rst)
      s.mem_re |-> s.mem_addr == $past(s.cur_addr[13:2]))
      else $error("memory read at wrong word");
   reg_drop_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_IN_CAP && s.wait_cnt == 3'h0 && s.opcode == `OP_REG_WRITE && !reg_hit
      |=> !s.reg_we && !s.mem_we) else $error("write outside register area landed");
   write_done_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_IN_CAP && s.wait_cnt == 3'h0 && s.remain == 32'h0000_0001
      |=> s.state == ST_CMD_WAIT && s.ep == `EP_COMMAND) else $error("no return after last word");
   oe_with_wr_a: assert property (@(posedge clk) disable iff (rst)
      s.dq_oe |-> s.wr) else $error("bus driven without write strobe");
   reg_read_one_a: assert property (@(posedge clk) disable iff (rst)
      s.state == ST_DECODE && s.opcode == `OP_REG_READ |=> s.state == ST_OUT
      && s.remain == 32'h0000_0001) else $error("register read not one word");

   reg_write_c: cover property (@(posedge clk) disable iff (rst) s.reg_we);
   reg_read_c: cover property (@(posedge clk) disable iff (rst)
      s.wr && s.opcode == `OP_REG_READ);
   mem_read_c: cover property (@(posedge clk) disable iff (rst)
      s.wr && s.opcode == `OP_MEM_READ && !fifo_in_ready);
   mem_write_c: cover property (@(posedge clk) disable iff (rst) s.mem_we);
   unknown_drop_c: cover property (@(posedge clk) disable iff (rst)
      s.state == ST_DECODE && !known_op(s.opcode));
endmodule
`default_nettype wire

// ==== src/word_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk,                 // core clock
   input wire logic rst,                 // async reset, active high
   input wire logic in_valid,            // push request
   output logic in_ready,                // room available
   input wire logic [WIDTH-1:0] in_data, // pushed word
   output logic out_valid,               // word available
   input wire logic out_ready,           // pop request
   output logic [WIDTH-1:0] out_data     // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wptr <= AW'(wptr + 1'b1);
         end
         if (pop) begin
            rptr <= AW'(rptr + 1'b1);
         end
         if (push && !pop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (pop && !push) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end

   // storage is not reset; only the pointers and count need a defined value
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ==== verif/bridge_model.sv ====
// behavioural model of the usb bridge slave fifo port
`default_nettype none
`include "cmd_if_regs.svh"
module bridge_model
   import cmd_if_pkg::*;
(
   input wire logic clk,            // core clock
   input wire logic [1:0] ep,       // endpoint select from device
   input wire logic rd,             // read strobe from device
   input wire logic wr,             // write strobe from device
   input wire logic [31:0] dq_out,  // data from device
   input wire logic dq_oe,          // device drives the bus
   input wire logic stall,          // hold off the device-to-host endpoint
   output logic flag = 1'b0,        // selected endpoint ready
   output logic [31:0] dq_in = 32'h5A5A_5A5A // data to device
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cmd_q[$];
   logic [31:0] h2d_q[$];
   logic [31:0] d2h_q[$];
   int hold = 0;
   // outputs change at the falling edge, clear of the device's sampling edge
   always @(negedge clk) begin
      if (rd) begin
         if (ep == `EP_COMMAND && cmd_q.size() > 0) begin
            dq_in <= cmd_q.pop_front();
         end else if (ep == `EP_HOST_TO_DEVICE && h2d_q.size() > 0) begin
            dq_in <= h2d_q.pop_front();
         end
         hold <= 4;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end else begin
         // released bus: toggle so a stale word is never mistaken for data
         dq_in <= ~dq_in;
      end
      if (wr && dq_oe && ep == `EP_DEVICE_TO_HOST) begin
         d2h_q.push_back(dq_out);
      end
      flag <= (ep == `EP_COMMAND && cmd_q.size() > 0) ||
              (ep == `EP_HOST_TO_DEVICE && h2d_q.size() > 0) ||
              (ep == `EP_DEVICE_TO_HOST && !stall);
   end
endmodule
`default_nettype wire

// ==== verif/tb_usb_fifo_command_interpreter.sv ====
// self-checking bench for the bridge command interpreter
`default_nettype none
`include "cmd_if_regs.svh"
module tb_usb_fifo_command_interpreter;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic stall = 1'b0;
   logic [1:0] bridge_ep;
   logic bridge_rd, bridge_wr, bridge_flag, bridge_dq_oe, mem_we, mem_re;
   logic [31:0] bridge_dq_in, bridge_dq_out, mem_wdata;
   logic [31:0] mem_rdata = 32'h0;
   logic [11:0] mem_addr;
   logic [31:0] mem [0:4095];
   int err_count = 0;
   int num_checks = 0;

   always #2 clk = ~clk;

   usb_fifo_command_interpreter u_usb_fifo_command_interpreter (
      .clk(clk), .rst(rst), .bridge_ep(bridge_ep), .bridge_rd(bridge_rd),
      .bridge_wr(bridge_wr), .bridge_flag(bridge_flag), .bridge_dq_in(bridge_dq_in),
      .bridge_dq_out(bridge_dq_out), .bridge_dq_oe(bridge_dq_oe), .mem_we(mem_we),
      .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   bridge_model u_bridge_model (
      .clk(clk), .ep(bridge_ep), .rd(bridge_rd), .wr(bridge_wr), .dq_out(bridge_dq_out),
      .dq_oe(bridge_dq_oe), .stall(stall), .flag(bridge_flag), .dq_in(bridge_dq_in));

   // memory: read data half a cycle after the strobe, then toggled so it is not held
   always @(negedge clk) begin
      if (mem_we) mem[mem_addr] <= mem_wdata;
      if (mem_re) mem_rdata <= mem[mem_addr];
      else mem_rdata <= ~mem_rdata;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // reserved word carries junk that must not matter
   task automatic send(input logic [31:0] op, input logic [31:0] addr, input logic [31:0] n);
      u_bridge_model.cmd_q.push_back(op);
      u_bridge_model.cmd_q.push_back(addr);
      u_bridge_model.cmd_q.push_back(n);
      u_bridge_model.cmd_q.push_back(32'hDEAD_BEEF);
   endtask

   task automatic wait_drained();
      int i;
      for (i = 0; i < 8000 && (u_bridge_model.cmd_q.size() > 0 ||
           u_bridge_model.h2d_q.size() > 0); i++) @(negedge clk);
      repeat (40) @(negedge clk);
   endtask

   task automatic wait_rx(input int n);
      int i;
      for (i = 0; i < 8000 && u_bridge_model.d2h_q.size() < n; i++) @(negedge clk);
      chk(32'(u_bridge_model.d2h_q.size()), 32'(n));
   endtask

   task automatic t_reg_access();
      send(`OP_REG_WRITE, `REG_LAST_ADDR, 32'h1);
      u_bridge_model.h2d_q.push_back(32'hCAFE_0054);
      send(`OP_REG_WRITE_END, 32'h0, 32'h0);
      send(`OP_REG_WRITE, 32'h0000_0058, 32'h1);
      u_bridge_model.h2d_q.push_back(32'h1111_1111);
      send(`OP_REG_READ, `REG_LAST_ADDR, 32'h1);
      send(`OP_REG_READ, 32'h0000_0058, 32'h1);
      send(`OP_REG_READ, 32'h0, 32'h1);
      wait_rx(3);
      if (u_bridge_model.d2h_q.size() == 3) begin
         chk(u_bridge_model.d2h_q.pop_front(), 32'hCAFE_0054);
         chk(u_bridge_model.d2h_q.pop_front(), 32'h0);
         chk(u_bridge_model.d2h_q.pop_front(), 32'h0);
      end
      u_bridge_model.d2h_q.delete();
   endtask

   task automatic t_mem_write();
      int i;
      send(`OP_MEM_WRITE, 32'h0000_4008, 32'h3);
      for (i = 0; i < 3; i++) u_bridge_model.h2d_q.push_back(32'hB000_0000 + i);
      send(`OP_MEM_WRITE_END, 32'h0, 32'h0);
      wait_drained();
      for (i = 0; i < 3; i++) chk(mem[2 + i], 32'hB000_0000 + i);
      chk(mem[1], 32'h0);
   endtask

   task automatic t_mem_read();
      int i;
      for (i = 0; i < 20; i++) mem[16 + i] = 32'hA500_0000 + i;
      stall = 1'b1;
      send(`OP_MEM_READ, 32'h0001_0040, 32'd20);
      repeat (800) @(negedge clk);
      chk(32'(u_bridge_model.d2h_q.size()), 32'h0);
      stall = 1'b0;
      wait_rx(20);
      for (i = 0; i < 20 && u_bridge_model.d2h_q.size() > 0; i++)
         chk(u_bridge_model.d2h_q.pop_front(), 32'hA500_0000 + i);
      u_bridge_model.d2h_q.delete();
   endtask

   task automatic t_unknown_op();
      u_bridge_model.h2d_q.push_back(32'h7777_0001);
      send(32'h0000_0003, 32'h0000_0004, 32'h1);
      send(`OP_MEM_WRITE, 32'h0, 32'h0);
      send(`OP_MEM_READ, 32'h0, 32'h0);
      send(`OP_REG_READ, `REG_LAST_ADDR, 32'h1);
      wait_rx(1);
      if (u_bridge_model.d2h_q.size() > 0)
         chk(u_bridge_model.d2h_q.pop_front(), 32'hCAFE_0054);
      chk(32'(u_bridge_model.h2d_q.size()), 32'h1);
      send(`OP_REG_WRITE, 32'h0000_0004, 32'h1);
      send(`OP_REG_READ, 32'h0000_0004, 32'h1);
      wait_rx(1);
      if (u_bridge_model.d2h_q.size() > 0)
         chk(u_bridge_model.d2h_q.pop_front(), 32'h7777_0001);
   endtask

   task automatic results();
      if (err_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #300000;
      err_count++;
      results();
   end

   initial begin
      foreach (mem[i]) mem[i] = 32'h0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      t_reg_access();
      t_mem_write();
      t_mem_read();
      t_unknown_op();
      results();
   end
endmodule
`default_nettype wire
